// >>> rtl/spf_regs.svh
// Register offsets, field positions, command codes and timing counts of the self-program control
// ----------------------------------------------------------------------------
// Operation
// R1 - Each erase, page write or lock write lasts between 3.7 ms and 4.5 ms.
// R2 - Without read-while-write support the section-busy bit always reads zero.
// R3 - Bit 5 is reserved: reads zero, writes ignored.
// R4 - Ready interrupt needs enable bit and global flag, lasts while enable bit clear.
// R5 - No ready interrupt during an EEPROM write or a store-program operation.
// R6 - Writing section read enable while filling clears the page buffer.
// R7 - Lock-set plus enable: load-program within three cycles returns lock or fuse bits.
// R8 - Page-write plus enable: store-program within four cycles writes the buffered page.
// R9 - Erase and write take the page from the upper pointer bits, ignore data.
// R10 - Page-write bit clears on completion or when four cycles pass unused.
// R11 - The core is halted for the whole page write or page erase.
// R12 - Page-erase plus enable: store-program within four cycles erases; clears after.
// R13 - Enable bit opens a four-cycle store-program window; other bit picks the action.
// R14 - Enable alone: store-program loads R1:R0 into buffer word from the pointer.
// R15 - Enable clears after store-program or timeout; stays high through erase and write.
// R16 - Low five bits outside the accepted patterns have no effect.
// R17 - Software waits for the enable bit to read zero before a new command.
// R18 - Software polls section-busy and re-enables section reads before returning.
// R19 - Read-while-write variants let boot code program any location, boot section too.
// R20 - Page erase is the erase and enable pattern followed by store-program.
// R21 - An EEPROM write blocks self-programming and fuse or lock reads.
// R22 - Page buffer clears after page write, section read enable and reset.
// R23 - Store-program with enable bit clear changes no flash, buffer or lock bits.
// ----------------------------------------------------------------------------
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// I/O address and reset value of the control/status register
`define SPF_CSR_ADDR 6'h37
`define SPF_CSR_RESET 8'h00

// Field positions
`define SPF_BIT_EN 0
`define SPF_BIT_ERASE 1
`define SPF_BIT_WRITE 2
`define SPF_BIT_LOCK 3
`define SPF_BIT_RWW 4
`define SPF_BIT_RSVD 5
`define SPF_BIT_BUSY 6
`define SPF_BIT_IE 7

// Accepted low-five-bit command patterns
`define SPF_PAT_RWW 5'h11
`define SPF_PAT_LOCK 5'h09
`define SPF_PAT_WRITE 5'h05
`define SPF_PAT_ERASE 5'h03
`define SPF_PAT_LOAD 5'h01

// Windows in core cycles
`define SPF_ARM_CYC 3'h4
`define SPF_LPM_CYC 3'h3

// Flash operation time, clock rate and derived cycle counts
`define SPF_T_MIN_NS 3700000
`define SPF_T_MAX_NS 4500000
`define SPF_CLK_MHZ 250
`define SPF_OP_MIN_CYC ((`SPF_T_MIN_NS * `SPF_CLK_MHZ + 999) / 1000)
`define SPF_OP_MAX_CYC ((`SPF_T_MAX_NS * `SPF_CLK_MHZ) / 1000)

// Value a never-loaded buffer word programs
`define SPF_BLANK_WORD 16'hffff

`endif

// >>> rtl/spf_pkg.sv
// Types shared by the self-program control logic
package spf_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_BUSY,
    ST_STREAM
  } spf_state_e;

  typedef logic [15:0] spf_word_t;
endpackage : spf_pkg

// >>> rtl/spf_op_timer.sv
// Down-counter that times one flash operation
`timescale 1ns/10ps
module spf_op_timer
  import spf_pkg::*;
#(
  parameter int CYCLES = 925000
) (
  input logic clk_sys_i, // Core clock
  input logic reset_i, // Async reset, high
  input logic start_i, // Start pulse
  output logic busy_o, // Operation running
  output logic done_o // Last cycle of operation
);
  localparam int W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad
    $error("spf_op_timer: CYCLES must be at least 1");
  end

  logic [W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A start while running is ignored; the sequencer never issues one
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else if (start_i && cnt_q == '0) begin
      cnt_q <= W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy_o = (cnt_q != '0);
  assign done_o = (cnt_q == W'(1));
endmodule : spf_op_timer

// >>> rtl/spf_ctrl.sv
// Self-program control: command register, timed window, page buffer and flash sequencing
`timescale 1ns/10ps
`include "spf_regs.svh"
module spf_ctrl
  import spf_pkg::*;
#(
  parameter int OP_CYCLES = `SPF_OP_MIN_CYC, // Flash operation length in cycles
  parameter int PAGE_WORDS = 32, // Words per flash page
  parameter bit RWW_SUPPORT = 1'b0 // Variant with read-while-write
) (
  input logic clk_sys_i, // Core clock
  input logic reset_i, // Async reset, high
  input logic [5:0] io_addr_i, // I/O register address
  input logic io_we_i, // I/O write strobe
  input logic io_re_i, // I/O read strobe
  input logic [7:0] io_wdata_i, // I/O write data
  output logic [7:0] io_rdata_o, // Read data, cycle after strobe
  input logic spm_i, // Store-program instruction pulse
  input logic lpm_i, // Load-program instruction pulse
  input logic [15:0] z_ptr_i, // Z pointer
  input logic [15:0] r1r0_i, // R1:R0 data word
  input logic global_int_i, // Global interrupt flag
  input logic eeprom_write_active_i, // EEPROM write running
  input logic [7:0] lock_bits_i, // Lock bits
  input logic [7:0] fuse_low_i, // Fuse low byte
  input logic [7:0] fuse_high_i, // Fuse high byte
  input logic [7:0] fuse_ext_i, // Extended fuse byte
  output logic lpm_take_o, // This load returns lock/fuse data
  output logic [7:0] lpm_data_o, // Lock/fuse byte, next cycle
  output logic cpu_halt_o, // Hold the core
  output logic ready_irq_o, // Ready interrupt request
  output logic flash_erase_o, // Erase page pulse
  output logic flash_we_o, // Page word write pulse
  output logic [14-$clog2(PAGE_WORDS):0] flash_page_o, // Page address
  output logic [$clog2(PAGE_WORDS)-1:0] flash_word_idx_o, // Word in page
  output spf_word_t flash_word_o, // Word to program
  output logic lock_we_o, // Lock bits write pulse
  output logic [7:0] lock_data_o // Lock bits to write
);
  localparam int PW = $clog2(PAGE_WORDS);
  localparam logic [7:0] CSR_RESET = `SPF_CSR_RESET;

  if (PAGE_WORDS < 2 || PAGE_WORDS > 128 || (1 << PW) != PAGE_WORDS) begin : g_bad
    $error("spf_ctrl: PAGE_WORDS must be a power of two from 2 to 128");
  end

  spf_state_e st_q;
  logic [4:0] cmd_q;
  logic [2:0] arm_q;
  logic ie_q;
  logic rww_busy_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [7:0] lpm_data_q;
  spf_word_t buf_q [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] valid_q;
  logic [PW-1:0] idx_q;
  logic [14-PW:0] page_q;
  logic [7:0] lock_q;
  logic erase_q;
  logic we_q;
  logic lock_we_q;
  logic [PW-1:0] widx_q;
  spf_word_t word_q;

  logic csr_wr;
  logic pat_ok;
  logic cmd_take;
  logic spm_hit;
  logic lpm_hit;
  logic timed_op;
  logic timeout;
  logic stream_end;
  logic go_idle;
  logic buf_clear;
  logic tmr_busy;
  logic tmr_done;
  logic [PW-1:0] widx;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Commands are only taken while no operation is pending; a busy
  // enable bit makes software wait, as the loader polls for it
  assign csr_wr = io_we_i && (io_addr_i == `SPF_CSR_ADDR);
  assign pat_ok = (io_wdata_i[4:0] == `SPF_PAT_RWW) || // R16
                  (io_wdata_i[4:0] == `SPF_PAT_LOCK) ||
                  (io_wdata_i[4:0] == `SPF_PAT_WRITE) ||
                  (io_wdata_i[4:0] == `SPF_PAT_ERASE) || // R20
                  (io_wdata_i[4:0] == `SPF_PAT_LOAD);
  assign cmd_take = csr_wr && pat_ok && (st_q == ST_IDLE) && !eeprom_write_active_i; // R21 R17

  // Store-program counts only inside the armed window
  assign spm_hit = spm_i && (st_q == ST_ARMED) && !eeprom_write_active_i; // R13 R23 R21
  // Load of lock/fuse data only in the first three armed cycles
  assign lpm_hit = lpm_i && (st_q == ST_ARMED) && cmd_q[`SPF_BIT_LOCK] && // R7
                   (arm_q > (`SPF_ARM_CYC - `SPF_LPM_CYC)) && !eeprom_write_active_i; // R21
  assign timed_op = cmd_q[`SPF_BIT_ERASE] || cmd_q[`SPF_BIT_WRITE] || cmd_q[`SPF_BIT_LOCK];
  assign timeout = (st_q == ST_ARMED) && (arm_q == 3'h1) && !spm_hit && !lpm_hit; // R13
  assign stream_end = (st_q == ST_STREAM) && (idx_q == PW'(PAGE_WORDS - 1));
  assign go_idle = (st_q == ST_ARMED && ((spm_hit && !timed_op) || lpm_hit || timeout)) ||
                   (st_q == ST_BUSY && tmr_done && !cmd_q[`SPF_BIT_WRITE]) ||
                   stream_end;
  assign widx = z_ptr_i[PW:1]; // R14

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= ST_IDLE;
      arm_q <= 3'h0;
      idx_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (cmd_take) begin
            st_q <= ST_ARMED;
            arm_q <= `SPF_ARM_CYC; // R13
          end
        end
        ST_ARMED: begin
          arm_q <= arm_q - 3'h1;
          if (spm_hit && timed_op) begin
            st_q <= ST_BUSY; // R8 R12
          end else if (go_idle) begin
            st_q <= ST_IDLE; // R10 R15
          end
        end
        ST_BUSY: begin
          idx_q <= '0;
          if (tmr_done) begin
            st_q <= cmd_q[`SPF_BIT_WRITE] ? ST_STREAM : ST_IDLE; // R1
          end
        end
        ST_STREAM: begin
          idx_q <= idx_q + PW'(1);
          if (stream_end) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  // Command bits self-clear when the sequencer returns to idle; the
  // enable bit therefore stays high through erase and write
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_q <= 5'h00;
    end else if (cmd_take) begin
      cmd_q <= io_wdata_i[4:0];
    end else if (go_idle) begin
      cmd_q <= 5'h00; // R10 R12 R15
    end
  end

  // Interrupt enable is plain storage; bit 5 is never stored
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ie_q <= CSR_RESET[`SPF_BIT_IE];
    end else if (csr_wr) begin
      ie_q <= io_wdata_i[`SPF_BIT_IE]; // R3
    end
  end

  // Section busy: set by erase/write only with RWW_SUPPORT, cleared by a read-enable store
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rww_busy_q <= 1'b0;
    end else if (spm_hit && (cmd_q[`SPF_BIT_ERASE] || cmd_q[`SPF_BIT_WRITE])) begin
      rww_busy_q <= RWW_SUPPORT; // R2 R19
    end else if (spm_hit && cmd_q[`SPF_BIT_RWW]) begin
      rww_busy_q <= 1'b0;
    end
  end

  // Read data is registered; busy bit forced low without the variant
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (io_re_i && io_addr_i == `SPF_CSR_ADDR) begin
      rdata_q <= {ie_q, rww_busy_q && RWW_SUPPORT, 1'b0, cmd_q}; // R2 R3
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Ready interrupt is a level, quiet during EEPROM or store-program
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ie_q && global_int_i && !cmd_q[`SPF_BIT_EN] && // R4
               !eeprom_write_active_i && (st_q == ST_IDLE); // R5
    end
  end

  // ----------------------------------------------------------------
  // Lock and fuse readback
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lpm_data_q <= 8'h00;
    end else if (lpm_hit) begin
      case (z_ptr_i[1:0]) // R7
        2'h0: lpm_data_q <= fuse_low_i;
        2'h1: lpm_data_q <= lock_bits_i;
        2'h2: lpm_data_q <= fuse_ext_i;
        default: lpm_data_q <= fuse_high_i;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Temporary page buffer
  // ----------------------------------------------------------------
  // Clears on a read-enable command write (even mid-fill), on its
  // store, and once the page write has streamed out
  assign buf_clear = (cmd_take && io_wdata_i[4:0] == `SPF_PAT_RWW) || // R6
                     (spm_hit && cmd_q[`SPF_BIT_RWW]) || stream_end; // R22

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      valid_q <= '0; // R22
    end else if (buf_clear) begin
      valid_q <= '0;
    end else if (spm_hit && cmd_q == `SPF_PAT_LOAD) begin
      valid_q[widx] <= 1'b1; // R14
    end
  end

  // Data array has no reset; valid bits mask stale contents
  always_ff @(posedge clk_sys_i) begin
    if (spm_hit && cmd_q == `SPF_PAT_LOAD) begin
      buf_q[widx] <= r1r0_i; // R14
    end
  end

  // ----------------------------------------------------------------
  // Operation capture and flash port
  // ----------------------------------------------------------------
  // Only the page part of Z is kept; R1:R0 is ignored for erase/write
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      page_q <= '0;
      lock_q <= 8'h00;
    end else if (spm_hit && timed_op) begin
      page_q <= z_ptr_i[15:PW+1]; // R9
      lock_q <= r1r0_i[7:0];
    end
  end

  // Erase and lock write commit at the end of the timed period
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      erase_q <= 1'b0;
      lock_we_q <= 1'b0;
    end else begin
      erase_q <= tmr_done && cmd_q[`SPF_BIT_ERASE]; // R12
      lock_we_q <= tmr_done && cmd_q[`SPF_BIT_LOCK];
    end
  end

  // Page write streams one word a cycle after the timed period
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      we_q <= 1'b0;
      widx_q <= '0;
      word_q <= 16'h0000;
    end else begin
      we_q <= (st_q == ST_STREAM); // R8
      widx_q <= idx_q;
      word_q <= valid_q[idx_q] ? buf_q[idx_q] : `SPF_BLANK_WORD;
    end
  end

  spf_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .start_i(spm_hit && timed_op), // R1
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  // Halt covers timing and streaming of erase and write
  assign cpu_halt_o = (st_q == ST_BUSY || st_q == ST_STREAM) &&
                      (cmd_q[`SPF_BIT_ERASE] || cmd_q[`SPF_BIT_WRITE]); // R11
  assign lpm_take_o = lpm_hit;
  assign lpm_data_o = lpm_data_q;
  assign io_rdata_o = rdata_q;
  assign ready_irq_o = irq_q;
  assign flash_erase_o = erase_q;
  assign flash_we_o = we_q;
  assign flash_page_o = page_q;
  assign flash_word_idx_o = widx_q;
  assign flash_word_o = word_q;
  assign lock_we_o = lock_we_q;
  assign lock_data_o = lock_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // Counts busy cycles of one timed operation
  logic [31:0] op_len_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      op_len_q <= 32'h0;
    end else if (st_q == ST_BUSY) begin
      op_len_q <= op_len_q + 32'h1;
    end else begin
      op_len_q <= 32'h0;
    end
  end

  a_op_length: assert property ($fell(tmr_busy) |-> op_len_q == 32'(OP_CYCLES)) // R1
    else $error("flash operation length wrong");
  a_busy_zero: assert property (!RWW_SUPPORT |-> !io_rdata_o[`SPF_BIT_BUSY]) // R2
    else $error("section busy read as one");
  a_reserved_zero: assert property (!io_rdata_o[`SPF_BIT_RSVD]) // R3
    else $error("reserved bit read as one");
  a_irq_cause: assert property (ready_irq_o |-> $past(ie_q && global_int_i && !cmd_q[0])) // R4
    else $error("interrupt without cause");
  a_irq_quiet: assert property ($past(eeprom_write_active_i) || $past(st_q != ST_IDLE)
                                |-> !ready_irq_o) // R5
    else $error("interrupt during write");
  a_rww_clear: assert property (cmd_take && io_wdata_i[4:0] == `SPF_PAT_RWW
                                |=> valid_q == '0) // R6
    else $error("buffer not cleared");
  a_arm_timeout: assert property (cmd_take ##1 (!spm_i && !lpm_i) [*4]
                                  |=> cmd_q == 5'h00 && st_q == ST_IDLE) // R15
    else $error("enable did not time out");
  a_halt_op: assert property (spm_hit && (cmd_q[1] || cmd_q[2]) |=> cpu_halt_o
                              throughout tmr_busy [*8]) // R11
    else $error("core not halted");
  a_bad_pattern: assert property (csr_wr && !pat_ok && st_q == ST_IDLE
                                  |=> st_q == ST_IDLE && cmd_q == 5'h00) // R16
    else $error("bad pattern took effect");
  a_spm_idle: assert property (spm_i && st_q == ST_IDLE |=> $stable(valid_q)
                               && !tmr_busy) // R23
    else $error("store acted while disabled");
  // First and last word of the stream, whatever the page size
  localparam int STREAM_LAST = PAGE_WORDS - 1;
  a_write_stream: assert property (tmr_done && cmd_q[2] |=> ##1 // R8
                                   (flash_we_o && flash_word_idx_o == '0) ##STREAM_LAST
                                   (flash_we_o && flash_word_idx_o == PW'(STREAM_LAST)))
    else $error("page write did not stream");

  c_erase: cover property (spm_hit && cmd_q == `SPF_PAT_ERASE);
  c_write: cover property (stream_end);
  c_load: cover property (spm_hit && cmd_q == `SPF_PAT_LOAD);
  c_lock_read: cover property (lpm_hit);
endmodule : spf_ctrl

// >>> tb/spf_core_model.sv
// Core model: control register writes and reads, store and load instruction pulses
`timescale 1ns/10ps
module spf_core_model (
  input logic clk_sys_i, // Core clock
  input logic halt_i, // Core held by the block
  output logic [5:0] io_addr_o, // Register address
  output logic io_we_o, // Write strobe
  output logic io_re_o, // Read strobe
  output logic [7:0] io_wdata_o, // Write data
  input logic [7:0] io_rdata_i, // Read data
  output logic spm_o, // Store-program pulse
  output logic lpm_o, // Load-program pulse
  input logic lpm_take_i, // Load served as lock/fuse read
  input logic [7:0] lpm_data_i, // Lock/fuse byte
  output logic [15:0] z_ptr_o, // Z pointer
  output logic [15:0] r1r0_o // Data word
);
  // ----------------------------------------------------------------
  // Bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    io_addr_o = 6'h37;
    io_we_o = 1'b0;
    io_re_o = 1'b0;
    io_wdata_o = 8'h00;
    spm_o = 1'b0;
    lpm_o = 1'b0;
    z_ptr_o = 16'h0000;
    r1r0_o = 16'h0000;
  end

  // Read strobe one cycle, data taken once the registered answer has landed
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    io_addr_o <= a;
    io_re_o <= 1'b1;
    @(posedge clk_sys_i);
    io_re_o <= 1'b0;
    io_addr_o <= 6'h37;
    #1 d = io_rdata_i;
  endtask : rd

  // A halted core issues nothing, so wait for halt to drop before polling
  task automatic wait_idle(output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      if (halt_i !== 1'b0) begin
        @(posedge clk_sys_i);
      end else begin
        rd(6'h37, d);
        ok = (d[0] === 1'b0);
      end
    end
  endtask : wait_idle

  // Timed sequence: control write, then store in the first cycle of the window
  task automatic cmd(input logic [7:0] v, input logic [15:0] z, input logic [15:0] d,
                     input logic st);
    @(posedge clk_sys_i);
    io_we_o <= 1'b1;
    io_wdata_o <= v;
    @(posedge clk_sys_i);
    io_we_o <= 1'b0;
    io_wdata_o <= ~v;
    z_ptr_o <= z;
    r1r0_o <= d;
    spm_o <= st;
    @(posedge clk_sys_i);
    spm_o <= 1'b0;
    r1r0_o <= ~d; // Released data must not look valid
  endtask : cmd

  // Lock-set write, then a load held over the first edge of its window
  task automatic lpm(input logic [15:0] z, output logic take, output logic [7:0] d);
    @(posedge clk_sys_i);
    io_we_o <= 1'b1;
    io_wdata_o <= 8'h09;
    @(posedge clk_sys_i);
    io_we_o <= 1'b0;
    z_ptr_o <= z;
    lpm_o <= 1'b1;
    @(posedge clk_sys_i);
    take = lpm_take_i;
    lpm_o <= 1'b0;
    #1 d = lpm_data_i;
  endtask : lpm
endmodule : spf_core_model

// >>> tb/self_program_flash_control_tb_top.sv
// Self-checking bench for the self-program control block
`timescale 1ns/10ps
module self_program_flash_control_tb_top;
  import spf_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int OPC = 20; // Shortened operation keeps the run brief
  localparam int PW = 4;
  localparam logic [12:0] PG = 13'h0a5;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] io_addr;
  logic io_we, io_re, spm, lpm, take, halt, irq, f_er, f_we, l_we;
  logic [7:0] io_wdata, io_rdata, l_dat, ldata, lpm_data;
  logic [15:0] z_ptr, r1r0, f_word;
  logic [12:0] f_page, wpage, epage;
  logic [1:0] f_idx;
  logic global_int = 1'b0;
  logic ee_busy = 1'b0;
  logic [15:0] words [PW];
  int nwe = 0, nerase = 0, nlock = 0, nhalt = 0, fails = 0, compares = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  spf_ctrl #(.OP_CYCLES(OPC), .PAGE_WORDS(PW), .RWW_SUPPORT(1'b0)) DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .io_addr_i(io_addr), .io_we_i(io_we),
    .io_re_i(io_re), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .spm_i(spm),
    .lpm_i(lpm), .z_ptr_i(z_ptr), .r1r0_i(r1r0), .global_int_i(global_int),
    .eeprom_write_active_i(ee_busy), .lock_bits_i(8'h3c), .fuse_low_i(8'h62),
    .fuse_high_i(8'hdf), .fuse_ext_i(8'hf9), .lpm_take_o(take), .lpm_data_o(lpm_data),
    .cpu_halt_o(halt), .ready_irq_o(irq), .flash_erase_o(f_er), .flash_we_o(f_we),
    .flash_page_o(f_page), .flash_word_idx_o(f_idx), .flash_word_o(f_word),
    .lock_we_o(l_we), .lock_data_o(l_dat));

  spf_core_model core (
    .clk_sys_i(clk_sys_i), .halt_i(halt), .io_addr_o(io_addr), .io_we_o(io_we),
    .io_re_o(io_re), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata), .spm_o(spm),
    .lpm_o(lpm), .lpm_take_i(take), .lpm_data_i(lpm_data), .z_ptr_o(z_ptr),
    .r1r0_o(r1r0));

  // Record flash-side pulses and halted cycles
  always @(posedge clk_sys_i) begin
    if (f_we === 1'b1) begin
      words[f_idx] = f_word;
      wpage = f_page;
      nwe++;
    end
    if (f_er === 1'b1) begin
      nerase++;
      epage = f_page;
    end
    if (l_we === 1'b1) begin
      nlock++;
      ldata = l_dat;
    end
    if (halt === 1'b1) nhalt++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // A poll that runs out is a mismatch and ends the run
  task automatic idle;
    logic ok;
    core.wait_idle(ok);
    if (ok !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask : idle

  function automatic logic [15:0] zp(input int idx, input logic lsb);
    return {PG, 2'(idx), lsb};
  endfunction : zp

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] bad [5] = '{8'h07, 8'h0f, 8'h13, 8'h0b, 8'h1d};
    core.rd(6'h37, d);
    check("reset value", d, 8'h00);
    core.rd(6'h36, d);
    check("unmapped read", d, 8'h00);
    core.cmd(8'hff, 16'h0000, 16'h0000, 1'b0);
    core.rd(6'h37, d);
    check("reserved and busy", d, 8'h80);
    foreach (bad[i]) begin
      core.cmd(bad[i], 16'h0000, 16'h0000, 1'b0);
      core.rd(6'h37, d);
      check("bad pattern", d, 8'h00);
    end
    $display("test regs done");
  endtask : t_regs

  // Each command except read-enable, left without its store, must lapse after the window
  task automatic t_window;
    logic [7:0] d;
    logic [7:0] pat [4] = '{8'h01, 8'h03, 8'h05, 8'h09};
    foreach (pat[i]) begin
      core.cmd(pat[i], zp(0, 1'b0), 16'h0000, 1'b0);
      core.rd(6'h37, d);
      check("window open", d, pat[i]);
      core.rd(6'h37, d);
      check("window lapse", d, 8'h00);
    end
    check("no operation", 16'(nwe + nerase + nlock), 16'h0000);
    $display("test window done");
  endtask : t_window

  task automatic page_write(input string what);
    foreach (words[i]) words[i] = 16'h0000;
    nwe = 0;
    nhalt = 0;
    core.cmd(8'h05, zp(0, 1'b0), 16'h1111, 1'b1);
    idle();
    check({what, " count"}, 16'(nwe), 16'(PW));
    check({what, " page"}, wpage, PG);
    check({what, " halt"}, 16'(nhalt >= OPC && nhalt <= OPC + PW + 4), 16'h0001);
  endtask : page_write

  task automatic t_fill_write;
    core.cmd(8'h00, zp(1, 1'b0), 16'h7777, 1'b1);
    idle();
    core.cmd(8'h01, zp(0, 1'b1), 16'h1234, 1'b1);
    idle();
    core.cmd(8'h01, zp(2, 1'b0), 16'habcd, 1'b1);
    idle();
    page_write("write");
    check("word 0", words[0], 16'h1234);
    check("word 1", words[1], 16'hffff);
    check("word 2", words[2], 16'habcd);
    page_write("rewrite");
    foreach (words[i]) check("cleared", words[i], 16'hffff);
    $display("test fill write done");
  endtask : t_fill_write

  task automatic t_rww;
    core.cmd(8'h01, zp(3, 1'b0), 16'h0f0f, 1'b1);
    idle();
    core.cmd(8'h11, zp(0, 1'b0), 16'h0000, 1'b1);
    idle();
    page_write("rww");
    check("dropped word", words[3], 16'hffff);
    $display("test rww done");
  endtask : t_rww

  task automatic t_erase_irq;
    logic t;
    logic [7:0] d;
    @(posedge clk_sys_i);
    global_int <= 1'b1;
    nhalt = 0;
    core.cmd(8'h83, zp(2, 1'b1), 16'h5555, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    #1 check("irq in operation", irq, 1'b0);
    idle();
    check("erase count", 16'(nerase), 16'h0001);
    check("erase page", epage, PG);
    check("erase halt", 16'(nhalt >= OPC && nhalt <= OPC + 2), 16'h0001);
    check("irq ready", irq, 1'b1);
    @(posedge clk_sys_i);
    global_int <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 check("irq masked", irq, 1'b0);
    @(posedge clk_sys_i);
    global_int <= 1'b1;
    ee_busy <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 check("irq eeprom", irq, 1'b0);
    core.cmd(8'h03, zp(0, 1'b0), 16'h0000, 1'b1);
    core.rd(6'h37, d);
    check("eeprom blocks", d, 8'h00);
    core.lpm(16'h0001, t, d);
    check("eeprom blocks load", t, 1'b0);
    repeat (OPC + 4) @(posedge clk_sys_i);
    check("no erase", 16'(nerase), 16'h0001);
    ee_busy <= 1'b0;
    global_int <= 1'b0;
    $display("test erase irq done");
  endtask : t_erase_irq

  task automatic t_lock;
    logic t;
    logic [7:0] d;
    logic [7:0] exp [4] = '{8'h62, 8'h3c, 8'hf9, 8'hdf};
    for (int i = 0; i < 4; i++) begin
      idle();
      core.lpm(16'(i), t, d);
      check("load served", t, 1'b1);
      check("load byte", d, exp[i]);
    end
    idle();
    core.cmd(8'h09, 16'h0000, 16'h00c3, 1'b1);
    idle();
    check("lock writes", 16'(nlock), 16'h0001);
    check("lock data", ldata, 8'hc3);
    $display("test lock done");
  endtask : t_lock

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    t_regs();
    t_window();
    t_fill_write();
    t_rww();
    t_erase_irq();
    t_lock();
    finish_test();
  end
endmodule : self_program_flash_control_tb_top
